// ===== hw/sfi_pkg.sv
// Shared constants, command codes, carriers and states of the serial frame interface.
// Assumes a single core clock; all link pins arrive asynchronously.
package sfi_pkg;

  localparam int WORD_W = 16;
  localparam int CMD_W = 4;
  localparam int CFG_W = 12;
  localparam int RES_W = 14;
  localparam int RES12_W = 12;
  localparam int CHAN_W = 3;

  // Bit counter figures
  localparam logic [4:0] BITS_PER_FRAME = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h04;
  localparam logic [4:0] COUNT_ZERO = 5'h00;
  localparam logic [4:0] COUNT_ONE = 5'h01;

  // Command field codes
  localparam logic [3:0] CMD_CH_LAST = 4'h7;
  localparam logic [3:0] CMD_RSVD_A = 4'h8;
  localparam logic [3:0] CMD_RSVD_B = 4'h9;
  localparam logic [3:0] CMD_WRITE_CFG = 4'hA;
  localparam logic [3:0] CMD_TEST_MID = 4'hB;
  localparam logic [3:0] CMD_TEST_NEG = 4'hC;
  localparam logic [3:0] CMD_TEST_POS = 4'hD;
  localparam logic [3:0] CMD_BUF_READ = 4'hE;
  localparam logic [3:0] CMD_HW_DEFAULT = 4'hF;

  // Configuration word values and fields
  localparam logic [11:0] CFG_POWERUP = 12'h000;
  localparam logic [11:0] CFG_DEFAULT = 12'h800;
  localparam int CFG_BIT_TWOS = 10;
  localparam int CFG_BIT_PSEUDO = 7;

  // Whole-word values and frame counts used during initialisation
  localparam logic [15:0] SW_INIT_WORD = 16'hA000;
  localparam logic [15:0] HW_INIT_WORD = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [1:0] HW_INIT_FRAMES = 2'h2;
  localparam logic [1:0] INIT_COUNT_ZERO = 2'h0;

  // Low bits padded below a result
  localparam logic [1:0] PAD14 = 2'h0;
  localparam logic [3:0] PAD12 = 4'h0;

  // Test voltage selections
  localparam logic [1:0] TEST_NONE = 2'h0;
  localparam logic [1:0] TEST_MID = 2'h1;
  localparam logic [1:0] TEST_NEG = 2'h2;
  localparam logic [1:0] TEST_POS = 2'h3;

  // Asynchronous pins sampled together
  typedef struct packed {
    logic csN;
    logic frameSync;
    logic sclk;
    logic serialIn;
    logic eightInputs;
    logic twelveBit;
  } sfi_pins_t;

  localparam sfi_pins_t PINS_IDLE = '{csN: 1'b1, frameSync: 1'b1, sclk: 1'b0,
                                      serialIn: 1'b1, eightInputs: 1'b0, twelveBit: 1'b0};

  // Conversion request to the converter core
  typedef struct packed {
    logic [2:0] channel;
    logic [1:0] testSel;
    logic pseudoDiff;
  } sfi_select_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COMMAND = 2'b01,
    ST_DATA = 2'b10,
    ST_CONVERT = 2'b11
  } sfi_state_t;

endpackage

// ===== hw/sfi_sync.sv
// Two-flop synchroniser for the grouped link pins.
// Assumes the pins are quasi-static relative to core_clk edges.
`timescale 1ns/1ps
module sfi_sync
  import sfi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire sfi_pins_t asyncIn,
  output sfi_pins_t syncOut
);

  sfi_pins_t stage1;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= PINS_IDLE;
      syncOut <= PINS_IDLE;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // sfi_sync

// ===== hw/sfi_result_fmt.sv
// Builds the 16-bit output word from a raw offset-binary conversion code.
// Assumes rawCode is offset binary, 14 bits, MSB aligned for the 12-bit variant.
`timescale 1ns/1ps
module sfi_result_fmt
  import sfi_pkg::*;
(
  input wire logic [RES_W-1:0] rawCode,
  input wire logic twosComplement,
  input wire logic twelveBit,
  output logic [WORD_W-1:0] wordOut
);

  // Offset binary to two's complement is an MSB inversion
  function automatic logic [RES_W-1:0] flipMsb(input logic [RES_W-1:0] v, input logic en);
    flipMsb = v;
    flipMsb[RES_W-1] = v[RES_W-1] ^ en;
  endfunction

  logic [RES_W-1:0] code;

  always_comb begin
    code = flipMsb(rawCode, twosComplement);
    if (twelveBit) begin
      wordOut = {code[RES_W-1 -: RES12_W], PAD12};
    end else begin
      wordOut = {code, PAD14};
    end
  end

endmodule // sfi_result_fmt

// ===== hw/serial_adc_frame_interface.sv
// Serial frame interface and operation-cycle control of a multichannel SAR converter.
// Assumes link pins are asynchronous to core_clk and SCLK is much slower than core_clk.
// Behaviour
// - Input word is 16 bits MSB first; top four command, low twelve data.
// - Output word is 16 bits; result left aligned, low bits don't care.
// - 14-bit offset binary: 0000h, 2000h, 3FFFh for negative, zero, positive.
// - 14-bit two's complement: 2000h, 0000h, 1FFFh for negative, zero, positive.
// - 12-bit offset binary: 000h, 800h, FFFh for negative, zero, positive.
// - 12-bit two's complement: 800h, 000h, 7FFh for negative, zero, positive.
// - After reset interrupt pin is high and input register is zero.
// - Two all-ones frames of 16 clocks after power-on load default 800h.
// - Default configuration: offset binary, long sampling, internal clock, single-ended.
// - Operation is command period, then conversions, ending at last conversion.
// - Frame sync sampled at chip-select fall chooses the start edge.
// - Chip select high: output released, input and clock ignored.
// - Chip-select fall clears counter and enables serial pins.
// - Frame-sync rise clears counter and enables pins; chip select may stay low.
// - First clock falling edge captures bit 15; output bit 15 valid before.
// - Later output bits shift on rising edges; input latched on falling.
// - Counter reaching 16 releases the serial output.
// - Output word is previous result, or buffer head when buffer used.
// - Pseudodifferential halves inputs: two pairs or four pairs.
// - Command decode: channels, write config, test voltages, buffer read, default.
// - Twelve data bits stored only for a configuration write.
// - Input ignored after count 16 or chip-select rise.
`timescale 1ns/1ps
module serial_adc_frame_interface
  import sfi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic csN,
  input wire logic frameSyncIn,
  input wire logic sclk,
  input wire logic serialIn,
  input wire logic eightInputVariant,
  input wire logic twelveBitVariant,
  input wire logic [RES_W-1:0] lastResult,
  input wire logic [RES_W-1:0] bufferHead,
  input wire logic bufferInUse,
  input wire logic convDone,
  input wire logic lastConversion,
  output logic serialOut,
  output logic serialOutEn,
  output logic intN,
  output logic [CFG_W-1:0] configWord,
  output logic hwDefaultMode,
  output logic softwareInit,
  output logic convStart,
  output sfi_select_t convSelect,
  output logic bufferPop,
  output logic bufferReset,
  output logic opBusy
);

  sfi_pins_t rawPins;
  sfi_pins_t pins;
  sfi_pins_t pinsPrev;
  logic csFall;
  logic csRise;
  logic fsRise;
  logic sclkRise;
  logic sclkFall;
  logic frameStart;
  logic waitForFs;
  logic active;
  logic [4:0] bitCount;
  logic [WORD_W-1:0] inShift;
  logic [WORD_W-1:0] outShift;
  logic [WORD_W-1:0] outWord;
  logic [RES_W-1:0] resultSrc;
  logic [WORD_W-1:0] next_inShift;
  logic captureBit;
  logic frameComplete;
  logic [CMD_W-1:0] command;
  logic [1:0] initFrames;
  logic cmdComplete;
  logic opEnd;
  logic hwInitFrame;
  logic hwInitLast;
  sfi_state_t state;

  assign rawPins = '{csN: csN, frameSync: frameSyncIn, sclk: sclk, serialIn: serialIn,
                     eightInputs: eightInputVariant, twelveBit: twelveBitVariant};

  sfi_sync u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(rawPins),
    .syncOut(pins)
  );

  // Edge detection on synchronised pins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinsPrev <= PINS_IDLE;
    end else begin
      pinsPrev <= pins;
    end
  end

  assign csFall = pinsPrev.csN & ~pins.csN;
  assign csRise = ~pinsPrev.csN & pins.csN;
  assign fsRise = ~pinsPrev.frameSync & pins.frameSync;
  assign sclkRise = ~pinsPrev.sclk & pins.sclk;
  assign sclkFall = pinsPrev.sclk & ~pins.sclk;

  // Start-edge selection; reset arms frame-sync start for a tied-low chip select
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitForFs <= 1'b1;
    end else if (csFall) begin
      waitForFs <= ~pins.frameSync;
    end
  end

  assign frameStart = (csFall & pins.frameSync)
                    | (fsRise & ~pins.csN & (waitForFs | csFall));

  // Input sampling enabled only inside a live frame
  assign captureBit = active & ~pins.csN & sclkFall & (bitCount < BITS_PER_FRAME);
  assign next_inShift = {inShift[WORD_W-2:0], pins.serialIn};
  assign frameComplete = captureBit & (bitCount == BITS_PER_FRAME - COUNT_ONE);
  assign cmdComplete = captureBit & (bitCount == CMD_BITS - COUNT_ONE);

  // Frame activity and bit counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
      bitCount <= COUNT_ZERO;
    end else if (frameStart) begin
      active <= 1'b1;
      bitCount <= COUNT_ZERO;
    end else if (csRise) begin
      active <= 1'b0;
    end else if (captureBit) begin
      bitCount <= bitCount + COUNT_ONE;
      if (frameComplete) begin
        active <= 1'b0;
      end
    end
  end

  // Input data register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      inShift <= WORD_ZERO;
    end else if (captureBit) begin
      inShift <= next_inShift;
    end
  end

  // Latch the command once its four bits are in
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      command <= CMD_WRITE_CFG;
    end else if (cmdComplete) begin
      command <= next_inShift[CMD_W-1:0];
    end
  end

  // Result source and formatting for the outgoing word
  assign resultSrc = bufferInUse ? bufferHead : lastResult;

  sfi_result_fmt u_fmt (
    .rawCode(resultSrc),
    .twosComplement(configWord[CFG_BIT_TWOS]),
    .twelveBit(pins.twelveBit),
    .wordOut(outWord)
  );

  // Serial output: MSB presented at frame start, then one bit per rising edge after the first falling edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outShift <= WORD_ZERO;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (frameStart) begin
      outShift <= {outWord[WORD_W-2:0], 1'b0};
      serialOut <= outWord[WORD_W-1];
      serialOutEn <= 1'b1;
    end else if (csRise || frameComplete) begin
      serialOutEn <= 1'b0;
    end else if (active && sclkRise && bitCount != COUNT_ZERO) begin
      serialOut <= outShift[WORD_W-1];
      outShift <= {outShift[WORD_W-2:0], 1'b0};
    end
  end

  // Consecutive all-ones frames after power-on, before any software init
  assign hwInitFrame = (next_inShift == HW_INIT_WORD) & ~softwareInit;
  assign hwInitLast = hwInitFrame & (initFrames == HW_INIT_FRAMES - 2'h1);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      initFrames <= INIT_COUNT_ZERO;
    end else if (frameComplete && initFrames != HW_INIT_FRAMES) begin
      if (hwInitFrame) begin
        initFrames <= initFrames + 2'h1;
      end else begin
        initFrames <= INIT_COUNT_ZERO;
      end
    end
  end

  // Configuration word: write command, or either default path
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      configWord <= CFG_POWERUP;
    end else if (frameComplete) begin
      if (command == CMD_WRITE_CFG) begin
        configWord <= next_inShift[CFG_W-1:0];
      end else if (command == CMD_HW_DEFAULT || hwInitLast) begin
        configWord <= CFG_DEFAULT;
      end
    end
  end

  // Initialisation mode flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hwDefaultMode <= 1'b0;
      softwareInit <= 1'b0;
    end else if (frameComplete) begin
      if (next_inShift == SW_INIT_WORD) begin
        softwareInit <= 1'b1;
        hwDefaultMode <= 1'b0;
      end else if (command == CMD_HW_DEFAULT || hwInitLast) begin
        hwDefaultMode <= 1'b1;
      end
    end
  end

  // Channel selection, including pseudodifferential pairing
  function automatic sfi_select_t decodeSelect(input logic [CMD_W-1:0] cmd,
                                               input logic pseudo,
                                               input logic eight);
    decodeSelect = '{channel: cmd[CHAN_W-1:0], testSel: TEST_NONE, pseudoDiff: pseudo};
    if (!eight) begin
      decodeSelect.channel[CHAN_W-1] = 1'b0;
    end
    if (pseudo) begin
      // Odd inputs serve as negative inputs of each pair
      decodeSelect.channel[0] = 1'b0;
      if (!eight) begin
        decodeSelect.channel[1] = cmd[0];
      end else begin
        decodeSelect.channel[2:1] = cmd[1:0];
      end
    end
    unique case (cmd)
      CMD_TEST_MID: decodeSelect.testSel = TEST_MID;
      CMD_TEST_NEG: decodeSelect.testSel = TEST_NEG;
      CMD_TEST_POS: decodeSelect.testSel = TEST_POS;
      default: decodeSelect.testSel = TEST_NONE;
    endcase
  endfunction

  function automatic logic isSelect(input logic [CMD_W-1:0] cmd);
    isSelect = (cmd <= CMD_CH_LAST) || (cmd >= CMD_TEST_MID && cmd <= CMD_TEST_POS);
  endfunction

  // Command execution strobes at the end of a complete frame
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      convStart <= 1'b0;
      bufferPop <= 1'b0;
      bufferReset <= 1'b0;
    end else begin
      convStart <= frameComplete & isSelect(command);
      bufferPop <= frameComplete & (command == CMD_BUF_READ);
      bufferReset <= frameComplete & (command == CMD_WRITE_CFG);
    end
  end

  // Selection held from the last accepted select command
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      convSelect <= '{channel: 3'h0, testSel: TEST_NONE, pseudoDiff: 1'b0};
    end else if (frameComplete && isSelect(command)) begin
      convSelect <= decodeSelect(command, configWord[CFG_BIT_PSEUDO], pins.eightInputs);
    end
  end

  // Last conversion of the operation cycle
  assign opEnd = convDone & lastConversion;

  // Operation cycle: command period, data period, conversions
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (frameStart) begin
            state <= ST_COMMAND;
          end
        end
        ST_COMMAND: begin
          if (csRise) begin
            state <= ST_IDLE;
          end else if (cmdComplete) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (csRise) begin
            state <= ST_IDLE;
          end else if (frameComplete) begin
            state <= isSelect(command) ? ST_CONVERT : ST_IDLE;
          end
        end
        ST_CONVERT: begin
          if (opEnd) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      opBusy <= 1'b0;
    end else begin
      // Drops with the last conversion rather than a cycle after
      opBusy <= (state != ST_IDLE) && !(state == ST_CONVERT && opEnd);
    end
  end

  // Interrupt pin: released at frame start, pulled low at end of conversion
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intN <= 1'b1;
    end else if (convDone) begin
      intN <= 1'b0;
    end else if (frameStart) begin
      intN <= 1'b1;
    end
  end

endmodule // serial_adc_frame_interface

// ===== bench/sfi_checker_assertions.sv
// Port-level checker of the serial frame interface.
// Assumes link pins change a few ns after a core_clk edge.
`timescale 1ns/1ps
module sfi_checker
  import sfi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic csN,
  input wire logic sclk,
  input wire logic convDone,
  input wire logic lastConversion,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic intN,
  input wire logic [CFG_W-1:0] configWord,
  input wire logic hwDefaultMode,
  input wire logic convStart,
  input wire logic bufferPop,
  input wire logic bufferReset,
  input wire logic opBusy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  rst_values_a: assert property ($rose(reset_n) |-> intN && configWord == CFG_POWERUP)
    else $error("reset values wrong");
  out_off_a: assert property (csN [*6] |-> !serialOutEn)
    else $error("output driven while deselected");
  en_cause_a: assert property (serialOutEn |-> !$past(csN, 3))
    else $error("output enabled without select");
  shift_rise_a: assert property ($changed(serialOut) && serialOutEn && $past(serialOutEn)
    |-> $past(sclk, 3))
    else $error("output bit moved off a rising edge");
  out_release_a: assert property ($fell(serialOutEn) |-> $past(csN, 3) || !$past(sclk, 3))
    else $error("output released without cause");
  pulse_end_a: assert property (convStart || bufferPop || bufferReset
    |-> $past(serialOutEn) && !serialOutEn)
    else $error("command pulse not at frame end");
  cfg_change_a: assert property ($changed(configWord)
    |-> bufferReset || configWord == CFG_DEFAULT)
    else $error("configuration changed without write");
  hw_default_a: assert property ($rose(hwDefaultMode) |-> configWord == CFG_DEFAULT)
    else $error("default mode without default word");
  int_low_a: assert property (convDone |=> !intN)
    else $error("end of conversion not flagged");
  op_end_a: assert property (convDone && lastConversion && opBusy |=> !opBusy)
    else $error("operation did not end");

  cover property (convStart);
  cover property (bufferPop);
  cover property ($rose(hwDefaultMode));
endmodule // sfi_checker

bind serial_adc_frame_interface sfi_checker i_sfi_checker (.core_clk(core_clk),
  .reset_n(reset_n), .csN(csN), .sclk(sclk), .convDone(convDone),
  .lastConversion(lastConversion), .serialOut(serialOut), .serialOutEn(serialOutEn),
  .intN(intN), .configWord(configWord), .hwDefaultMode(hwDefaultMode),
  .convStart(convStart), .bufferPop(bufferPop), .bufferReset(bufferReset), .opBusy(opBusy));

// ===== bench/sfi_host.sv
// Host serial port model: frames started by chip select or frame sync.
// Assumes calls begin a few ns after a core_clk edge; all steps are 20 ns multiples.
`timescale 1ns/1ps
module sfi_host (
  output logic csN,
  output logic frameSync,
  output logic sclk,
  output logic serialIn,
  input wire logic serialOut
);
  initial begin
    csN = 1'b1;
    frameSync = 1'b1;
    sclk = 1'b0;
    serialIn = 1'b1;
  end

  task automatic xfer(input logic fsMode, input logic [15:0] din, input int n,
                      output logic [15:0] dout);
    dout = '0;
    serialIn = din[15];
    frameSync = !fsMode;
    #160 csN = 1'b0;
    if (fsMode) begin
      #160 frameSync = 1'b1;
    end
    #80;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      #80 sclk = 1'b0;
      if (fsMode && i == 0) frameSync = 1'b0;
      #40;
      if (i < 16) dout[15-i] = serialOut;
      serialIn = (i < 15) ? din[14-i] : ~serialIn;
      #40;
    end
    csN = 1'b1;
    serialIn = ~serialIn;
    #160 frameSync = 1'b1;
    #160;
  endtask
endmodule // sfi_host

// ===== bench/testbench.sv
// Self-checking bench of the serial frame interface with a host model.
// Assumes the converter side is driven by the bench itself.
`timescale 1ns/1ps
module testbench;
  import sfi_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic eightInputVariant = 1'b0;
  logic twelveBitVariant = 1'b0;
  logic [RES_W-1:0] lastResult = '0;
  logic [RES_W-1:0] bufferHead = '0;
  logic bufferInUse = 1'b0;
  logic convDone = 1'b0;
  logic lastConversion = 1'b0;
  logic csN, frameSyncIn, sclk, serialIn, serialOut, serialOutEn, intN;
  logic sdoLine;
  logic hwDefaultMode, softwareInit, convStart, bufferPop, bufferReset, opBusy;
  logic [CFG_W-1:0] configWord;
  sfi_select_t convSelect;
  sfi_select_t selSeen = '0;
  int starts = 0;
  int pops = 0;
  int fails = 0;
  int checked = 0;
  int seed;
  int n0;
  logic tw;
  logic [2:0] ch;
  logic [11:0] cfg;
  logic [13:0] raw;
  logic [15:0] word;
  logic [13:0] corner [4] = '{14'h0000, 14'h2000, 14'h3FFF, 14'h0000};

  always #10 core_clk = ~core_clk;

  sfi_host i_sfi_host (.csN(csN), .frameSync(frameSyncIn), .sclk(sclk),
    .serialIn(serialIn), .serialOut(sdoLine));

  // Released line reads as the inverse of the last bit
  assign sdoLine = serialOutEn ? serialOut : ~serialOut;

  serial_adc_frame_interface i_serial_adc_frame_interface (.core_clk(core_clk),
    .reset_n(reset_n), .csN(csN), .frameSyncIn(frameSyncIn), .sclk(sclk),
    .serialIn(serialIn), .eightInputVariant(eightInputVariant),
    .twelveBitVariant(twelveBitVariant), .lastResult(lastResult), .bufferHead(bufferHead),
    .bufferInUse(bufferInUse), .convDone(convDone), .lastConversion(lastConversion),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .intN(intN), .configWord(configWord),
    .hwDefaultMode(hwDefaultMode), .softwareInit(softwareInit), .convStart(convStart),
    .convSelect(convSelect), .bufferPop(bufferPop), .bufferReset(bufferReset),
    .opBusy(opBusy));

  always @(posedge core_clk) begin
    if (convStart === 1'b1) begin
      selSeen <= convSelect;
      starts <= starts + 1;
    end
    if (bufferPop === 1'b1) pops <= pops + 1;
  end

  function automatic logic [15:0] fmt(input logic [13:0] r, input logic t, input logic b);
    logic [13:0] v;
    v = r ^ {t, 13'h0000};
    fmt = b ? {v[13:2], 4'h0} : {v, 2'h0};
  endfunction

  function automatic logic [5:0] expSel(input logic [2:0] c, input logic e, input logic p);
    logic [2:0] chan;
    chan = e ? c : {1'b0, c[1:0]};
    if (p) chan = e ? {c[1:0], 1'b0} : {1'b0, c[0], 1'b0};
    expSel = {chan, TEST_NONE, p};
  endfunction

  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic run(input logic fsm, input logic [15:0] w, input int n);
    i_sfi_host.xfer(fsm, w, n, word);
  endtask

  task automatic conv;
    convDone = 1'b1;
    lastConversion = 1'b1;
    @(posedge core_clk);
    #2 convDone = 1'b0;
    @(posedge core_clk);
    #2 chk("intN", 16'(intN), 16'h0000);
    chk("opBusy", 16'(opBusy), 16'h0000);
  endtask

  initial begin
    #1000000;
    fails++;
    give_verdict();
  end

  initial begin
    seed = 77226;
    repeat (8) @(posedge core_clk);
    #2 reset_n = 1'b1;
    @(posedge core_clk);
    #2 chk("intN", 16'(intN), 16'h0001);
    chk("configWord", 16'(configWord), 16'(CFG_POWERUP));
    run(1'b0, HW_INIT_WORD, 16);
    run(1'b1, HW_INIT_WORD, 16);
    chk("configWord", 16'(configWord), 16'(CFG_DEFAULT));
    chk("hwDefaultMode", 16'(hwDefaultMode), 16'h0001);
    for (int k = 0; k < 16; k++) begin
      tw = k[0];
      twelveBitVariant = k[1];
      eightInputVariant = k[2];
      raw = corner[k[3:2]];
      if (k[3:2] == 2'h3) raw = 14'($random(seed));
      cfg = CFG_DEFAULT | (12'(tw) << CFG_BIT_TWOS) | (12'(k[3]) << CFG_BIT_PSEUDO);
      run(k[1], {CMD_WRITE_CFG, cfg}, 16 + k[1:0]);
      chk("configWord", 16'(configWord), 16'(cfg));
      lastResult = raw;
      ch = 3'($random(seed));
      run(k[0], {1'b0, ch, 12'h000}, 16);
      chk("word", word, fmt(raw, tw, k[1]));
      chk("select", 16'(selSeen), 16'(expSel(ch, eightInputVariant, k[3])));
      chk("configWord", 16'(configWord), 16'(cfg));
      conv();
    end
    for (int c = 11; c < 14; c++) begin
      run(1'b0, {4'(c), 12'h000}, 16);
      chk("testSel", 16'(selSeen.testSel), 16'(c - 10));
      conv();
    end
    n0 = starts;
    run(1'b0, {CMD_RSVD_A, 12'h000}, 16);
    run(1'b1, {CMD_RSVD_B, 12'h000}, 16);
    run(1'b0, {CMD_WRITE_CFG, ~cfg}, 8);
    chk("configWord", 16'(configWord), 16'(cfg));
    chk("starts", 16'(starts - n0), 16'h0000);
    bufferInUse = 1'b1;
    bufferHead = 14'($random(seed));
    n0 = pops;
    run(1'b1, {CMD_BUF_READ, 12'h000}, 16);
    chk("buffer word", word, fmt(bufferHead, tw, twelveBitVariant));
    chk("pops", 16'(pops - n0), 16'h0001);
    run(1'b0, {CMD_HW_DEFAULT, 12'h000}, 16);
    chk("configWord", 16'(configWord), 16'(CFG_DEFAULT));
    run(1'b0, SW_INIT_WORD, 16);
    chk("softwareInit", 16'(softwareInit), 16'h0001);
    give_verdict();
  end
endmodule // testbench
